/* core/dual_timer_consts.svh */
// register indices, field positions and reset values of the dual counter/timer
// assumes: byte address on the bus is four times the register index
`ifndef DUAL_TIMER_CONSTS_SVH
`define DUAL_TIMER_CONSTS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define IDX_TIMER_CONTROL      8'h80
`define IDX_TIMER_MODE         8'h81
`define IDX_FIRST_LOW          8'h82
`define IDX_SECOND_LOW         8'h83
`define IDX_FIRST_HIGH         8'h84
`define IDX_SECOND_HIGH        8'h85
`define IDX_TIMER_CLOCK_SELECT 8'h8E
`define IDX_GATE_POLARITY      8'h90
`define IDX_IRQ_STATUS         8'h91
`define IDX_IRQ_ENABLE         8'h92

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CTL_FIRST_RUN          4
`define CTL_FIRST_OVF          5
`define CTL_SECOND_RUN         6
`define CTL_SECOND_OVF         7
`define MODE_FIRST_LSB         0
`define MODE_FIRST_CT          2
`define MODE_FIRST_GATE        3
`define MODE_SECOND_LSB        4
`define MODE_SECOND_CT         6
`define MODE_SECOND_GATE       7
`define CKS_PRESCALE_LSB       0
`define CKS_FIRST_SYSCLK       3
`define CKS_SECOND_SYSCLK      4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_BYTE               8'h00
`define RST_PAIR               2'h0

`endif

/* core/dual_timer_pkg.sv */
// types shared by the dual counter/timer
// assumes: nothing beyond the constants header
package dual_timer_pkg;

	// operating mode of one timer, as held in its two mode bits
	typedef enum logic [1:0] {
		MODE_13BIT  = 2'h0,
		MODE_16BIT  = 2'h1,
		MODE_RELOAD = 2'h2,
		MODE_SPLIT  = 2'h3
	} tmode_e;

endpackage : dual_timer_pkg

/* core/dual_classic_counter_timer.sv */
// two classic 16-bit counter/timers behind a classic Wishbone slave
// assumes: one clock, synchronous active-high reset, pins async to clk_i
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`include "dual_timer_consts.svh"

module dual_classic_counter_timer
	import dual_timer_pkg::*;
#(
	parameter logic [7:0] PRESC_DIV0 = 8'h0C,  // prescale select 0: clk/12
	parameter logic [7:0] PRESC_DIV1 = 8'h04,  // prescale select 1: clk/4
	parameter logic [7:0] PRESC_DIV2 = 8'h30   // prescale select 2: clk/48
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [11:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        first_event_pin_i,
	input  wire logic        second_event_pin_i,
	input  wire logic        first_ext_gate_input_i,
	input  wire logic        second_ext_gate_input_i,
	input  wire logic        ext_scaled_tick_i,
	input  wire logic [1:0]  irq_vector_ack_i,
	output logic             second_overflow_pulse_o,
	output logic             irq_o
);

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	logic [7:0]  timer_clock_select_q;
	logic [7:0]  timer_mode_q;
	logic [7:0]  first_timer_low_byte_q;
	logic [7:0]  first_timer_high_byte_q;
	logic [7:0]  second_timer_low_byte_q;
	logic [7:0]  second_timer_high_byte_q;
	logic        first_timer_run_q;
	logic        second_timer_run_q;
	logic        first_timer_overflow_flag_q;
	logic        second_timer_overflow_flag_q;
	logic [1:0]  gate_polarity_q;
	logic [1:0]  irq_status_q;
	logic [1:0]  irq_enable_q;
	logic [1:0]  evt_s1_q;
	logic [1:0]  evt_s2_q;
	logic [1:0]  evt_s3_q;
	logic [1:0]  gate_s1_q;
	logic [1:0]  gate_s2_q;
	logic [7:0]  presc_cnt_q;
	logic        ack_q;
	logic [31:0] dat_q;
	logic        irq_q;
	logic        ovf_pulse_q;

	// ------------------------------------------------------------------------
	// one step of a timer in modes 0..2, or the low byte in split mode
	// result is {overflow, new high, new low}
	// ------------------------------------------------------------------------
	function automatic logic [16:0] step_f(input logic [1:0] md, input logic [7:0] lo, input logic [7:0] hi);
		logic [12:0] c13;
		logic [15:0] c16;
		logic [16:0] r;
		c13 = {hi, lo[4:0]} + 13'h0001;
		c16 = {hi, lo} + 16'h0001;
		case (md)
			MODE_13BIT: begin
				// upper low-byte bits are left alone; they are not part of the count
				r = {c13 == 13'h0000, c13[12:5], lo[7:5], c13[4:0]};
			end
			MODE_16BIT: begin
				r = {c16 == 16'h0000, c16};
			end
			MODE_RELOAD: begin
				r = (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
			end
			default: begin
				r = {lo == 8'hFF, hi, lo + 8'h01};
			end
		endcase
		return r;
	endfunction : step_f

	// ------------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------------
	logic       req;
	logic       wr;
	logic [7:0] idx;
	assign req = cyc_i & stb_i & ~ack_q;
	assign wr  = req & we_i & sel_i[0];
	assign idx = adr_i[9:2];

	function automatic logic hit_f(input logic w, input logic [7:0] a, input logic [7:0] r);
		return w && (a == r);
	endfunction : hit_f

	logic wr_ctl, wr_mode, wr_l0, wr_l1, wr_h0, wr_h1, wr_cks, wr_pol, wr_st, wr_en;
	assign wr_ctl  = hit_f(wr, idx, `IDX_TIMER_CONTROL);
	assign wr_mode = hit_f(wr, idx, `IDX_TIMER_MODE);
	assign wr_l0   = hit_f(wr, idx, `IDX_FIRST_LOW);
	assign wr_l1   = hit_f(wr, idx, `IDX_SECOND_LOW);
	assign wr_h0   = hit_f(wr, idx, `IDX_FIRST_HIGH);
	assign wr_h1   = hit_f(wr, idx, `IDX_SECOND_HIGH);
	assign wr_cks  = hit_f(wr, idx, `IDX_TIMER_CLOCK_SELECT);
	assign wr_pol  = hit_f(wr, idx, `IDX_GATE_POLARITY);
	assign wr_st   = hit_f(wr, idx, `IDX_IRQ_STATUS);
	assign wr_en   = hit_f(wr, idx, `IDX_IRQ_ENABLE);

	// ------------------------------------------------------------------------
	// pin synchronisers; the first stage feeds only the second
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_s1_q  <= 2'h3;
			evt_s2_q  <= 2'h3;
			evt_s3_q  <= 2'h3;
			gate_s1_q <= `RST_PAIR;
			gate_s2_q <= `RST_PAIR;
		end else begin
			evt_s1_q  <= {second_event_pin_i, first_event_pin_i};
			evt_s2_q  <= evt_s1_q;
			evt_s3_q  <= evt_s2_q;
			gate_s1_q <= {second_ext_gate_input_i, first_ext_gate_input_i};
			gate_s2_q <= gate_s1_q;
		end
	end

	// a fall is a high sample followed by a low one; needs one-clock levels
	logic [1:0] fall;
	assign fall = evt_s3_q & ~evt_s2_q;

	// ------------------------------------------------------------------------
	// shared prescaler; select 3 takes an externally scaled tick
	// ------------------------------------------------------------------------
	logic [1:0] presc_sel;
	logic [7:0] presc_div;
	logic       presc_tick;
	assign presc_sel = timer_clock_select_q[`CKS_PRESCALE_LSB +: 2];
	always_comb begin
		case (presc_sel)
			2'h0:    presc_div = PRESC_DIV0;
			2'h1:    presc_div = PRESC_DIV1;
			default: presc_div = PRESC_DIV2;
		endcase
	end
	assign presc_tick = (presc_sel == 2'h3) ? ext_scaled_tick_i : (presc_cnt_q >= presc_div - 8'h01);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			presc_cnt_q <= `RST_BYTE;
		end else if (presc_cnt_q >= presc_div - 8'h01) begin
			presc_cnt_q <= `RST_BYTE;
		end else begin
			presc_cnt_q <= presc_cnt_q + 8'h01;
		end
	end

	// ------------------------------------------------------------------------
	// run, gate and clock choice for both timers
	// ------------------------------------------------------------------------
	logic [1:0] md0, md1;
	logic       split, sys0, sys1, run0, run1, tick0, tick1, tick_h0;
	logic [16:0] st0, st1;
	logic       ovf0, ovf1, ovf_h0, set_tf0, set_tf1;
	assign md0   = timer_mode_q[`MODE_FIRST_LSB +: 2];
	assign md1   = timer_mode_q[`MODE_SECOND_LSB +: 2];
	assign split = (md0 == MODE_SPLIT);
	assign sys0  = timer_clock_select_q[`CKS_FIRST_SYSCLK] ? 1'b1 : presc_tick;
	assign sys1  = timer_clock_select_q[`CKS_SECOND_SYSCLK] ? 1'b1 : presc_tick;
	assign run0  = first_timer_run_q &
	               (~timer_mode_q[`MODE_FIRST_GATE] | (gate_s2_q[0] == gate_polarity_q[0]));
	// while the first timer is split, mode alone starts or stops the second
	assign run1  = (md1 != MODE_SPLIT) & (split ? 1'b1 : (second_timer_run_q &
	               (~timer_mode_q[`MODE_SECOND_GATE] | (gate_s2_q[1] == gate_polarity_q[1]))));
	assign tick0 = run0 & (timer_mode_q[`MODE_FIRST_CT] ? fall[0] : sys0);
	assign tick1 = run1 & ((timer_mode_q[`MODE_SECOND_CT] & ~split) ? fall[1] : sys1);
	assign tick_h0 = split & second_timer_run_q & sys0;
	assign st0   = step_f(md0, first_timer_low_byte_q, first_timer_high_byte_q);
	assign st1   = step_f(md1, second_timer_low_byte_q, second_timer_high_byte_q);
	assign ovf0  = tick0 & st0[16];
	assign ovf1  = tick1 & st1[16];
	assign ovf_h0 = tick_h0 & (first_timer_high_byte_q == 8'hFF);
	assign set_tf0 = ovf0;
	assign set_tf1 = split ? ovf_h0 : ovf1;

	// ------------------------------------------------------------------------
	// count registers; a software write wins over a count in the same cycle
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first_timer_low_byte_q <= `RST_BYTE;
		end else if (wr_l0) begin
			first_timer_low_byte_q <= dat_i[7:0];
		end else if (tick0) begin
			first_timer_low_byte_q <= st0[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first_timer_high_byte_q <= `RST_BYTE;
		end else if (wr_h0) begin
			first_timer_high_byte_q <= dat_i[7:0];
		end else if (tick_h0) begin
			first_timer_high_byte_q <= first_timer_high_byte_q + 8'h01;
		end else if (tick0 && !split) begin
			first_timer_high_byte_q <= st0[15:8];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			second_timer_low_byte_q  <= `RST_BYTE;
			second_timer_high_byte_q <= `RST_BYTE;
		end else begin
			if (wr_l1) begin
				second_timer_low_byte_q <= dat_i[7:0];
			end else if (tick1) begin
				second_timer_low_byte_q <= st1[7:0];
			end
			if (wr_h1) begin
				second_timer_high_byte_q <= dat_i[7:0];
			end else if (tick1) begin
				second_timer_high_byte_q <= st1[15:8];
			end
		end
	end

	// ------------------------------------------------------------------------
	// control, mode and clock select; run writes never touch the count
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first_timer_run_q    <= 1'b0;
			second_timer_run_q   <= 1'b0;
			timer_mode_q         <= `RST_BYTE;
			timer_clock_select_q <= `RST_BYTE;
			gate_polarity_q      <= `RST_PAIR;
			irq_enable_q         <= `RST_PAIR;
		end else begin
			if (wr_ctl) begin
				first_timer_run_q  <= dat_i[`CTL_FIRST_RUN];
				second_timer_run_q <= dat_i[`CTL_SECOND_RUN];
			end
			if (wr_mode) begin
				timer_mode_q <= dat_i[7:0];
			end
			if (wr_cks) begin
				timer_clock_select_q <= dat_i[7:0];
			end
			if (wr_pol) begin
				gate_polarity_q <= dat_i[1:0];
			end
			if (wr_en) begin
				irq_enable_q <= dat_i[1:0];
			end
		end
	end

	// ------------------------------------------------------------------------
	// overflow flags: cleared by a zero write or a vector ack; a set wins
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first_timer_overflow_flag_q  <= 1'b0;
			second_timer_overflow_flag_q <= 1'b0;
		end else begin
			if (set_tf0) begin
				first_timer_overflow_flag_q <= 1'b1;
			end else if ((wr_ctl && !dat_i[`CTL_FIRST_OVF]) || irq_vector_ack_i[0]) begin
				first_timer_overflow_flag_q <= 1'b0;
			end
			if (set_tf1) begin
				second_timer_overflow_flag_q <= 1'b1;
			end else if ((wr_ctl && !dat_i[`CTL_SECOND_OVF]) || irq_vector_ack_i[1]) begin
				second_timer_overflow_flag_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// sticky interrupt status, write one to clear, set wins; level output
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status_q <= `RST_PAIR;
			irq_q        <= 1'b0;
			ovf_pulse_q  <= 1'b0;
		end else begin
			irq_status_q <= (irq_status_q & ~(wr_st ? dat_i[1:0] : 2'h0)) | {set_tf1, set_tf0};
			irq_q        <= |(irq_status_q & irq_enable_q);
			// raw second-timer overflow for baud and converter start, even when split
			ovf_pulse_q  <= ovf1;
		end
	end

	// ------------------------------------------------------------------------
	// bus answer: ack one cycle after the request, unmapped reads give zero
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req && !we_i) begin
				if (idx == `IDX_TIMER_CONTROL) begin
					dat_q <= {24'h000000, second_timer_overflow_flag_q, second_timer_run_q,
					          first_timer_overflow_flag_q, first_timer_run_q, 4'h0};
				end else if (idx == `IDX_TIMER_MODE) begin
					dat_q <= {24'h000000, timer_mode_q};
				end else if (idx == `IDX_FIRST_LOW) begin
					dat_q <= {24'h000000, first_timer_low_byte_q};
				end else if (idx == `IDX_SECOND_LOW) begin
					dat_q <= {24'h000000, second_timer_low_byte_q};
				end else if (idx == `IDX_FIRST_HIGH) begin
					dat_q <= {24'h000000, first_timer_high_byte_q};
				end else if (idx == `IDX_SECOND_HIGH) begin
					dat_q <= {24'h000000, second_timer_high_byte_q};
				end else if (idx == `IDX_TIMER_CLOCK_SELECT) begin
					dat_q <= {24'h000000, timer_clock_select_q};
				end else if (idx == `IDX_GATE_POLARITY) begin
					dat_q <= {30'h0, gate_polarity_q};
				end else if (idx == `IDX_IRQ_STATUS) begin
					dat_q <= {30'h0, irq_status_q};
				end else if (idx == `IDX_IRQ_ENABLE) begin
					dat_q <= {30'h0, irq_enable_q};
				end else begin
					dat_q <= 32'h0000_0000;
				end
			end
		end
	end

	assign dat_o                   = dat_q;
	assign ack_o                   = ack_q;
	assign irq_o                   = irq_q;
	assign second_overflow_pulse_o = ovf_pulse_q;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_TF0_SET: assert property (
		ovf0 |=> first_timer_overflow_flag_q) else $error("first overflow flag not set");
	AST_RELOAD: assert property (
		(md1 == MODE_RELOAD) && tick1 && (second_timer_low_byte_q == 8'hFF) && !wr_l1 && !wr_h1
		|=> second_timer_low_byte_q == $past(second_timer_high_byte_q) && $stable(second_timer_high_byte_q))
		else $error("reload did not copy high byte");
	AST_HOLD_STOPPED: assert property (
		!run0 && !split && !wr_l0 && !wr_h0 |=> $stable(first_timer_low_byte_q) && $stable(first_timer_high_byte_q))
		else $error("stopped timer changed");
	AST_EDGE_COUNT: assert property (
		(md0 == MODE_16BIT) && timer_mode_q[`MODE_FIRST_CT] && run0 && fall[0] && !wr_l0
		&& (first_timer_low_byte_q != 8'hFF) |=> first_timer_low_byte_q == $past(first_timer_low_byte_q) + 8'h01)
		else $error("falling edge not counted");
	AST_SYSCLK_COUNT: assert property (
		(md0 == MODE_16BIT) && !timer_mode_q[`MODE_FIRST_CT] && timer_clock_select_q[`CKS_FIRST_SYSCLK]
		&& run0 && !wr_l0 && (first_timer_low_byte_q != 8'hFF)
		|=> first_timer_low_byte_q == $past(first_timer_low_byte_q) + 8'h01)
		else $error("system clock did not count");
	AST_SPLIT_FLAG: assert property (
		ovf_h0 |=> second_timer_overflow_flag_q && first_timer_high_byte_q == 8'h00)
		else $error("split high byte overflow lost");
	AST_SECOND_STOP: assert property (
		(md1 == MODE_SPLIT) && !wr_l1 && !wr_h1
		|=> $stable(second_timer_low_byte_q) && $stable(second_timer_high_byte_q))
		else $error("second timer ran in mode three");
	AST_RUN_KEEPS: assert property (
		wr_ctl && dat_i[`CTL_FIRST_RUN] && !first_timer_run_q && !wr_l0 && !wr_h0
		|=> first_timer_low_byte_q == $past(first_timer_low_byte_q)) else $error("run cleared count");
	AST_MODE0_TOP: assert property (
		(md0 == MODE_13BIT) && tick0 && !wr_l0 |=> first_timer_low_byte_q[7:5] == $past(first_timer_low_byte_q[7:5]))
		else $error("13-bit count touched upper low bits");
	AST_SYNC_FALL: assert property (
		fall[0] |-> $past(evt_s1_q[0], 2) && !$past(evt_s1_q[0], 1)) else $error("fall without synchronised edge");
	AST_ACK: assert property (
		req |=> ack_o ##1 !ack_o) else $error("bus ack not a single cycle");

endmodule : dual_classic_counter_timer

/* tb/timer_pins_model.sv */
// far-side model: event pins and external gate inputs of the dual timer
// assumes: bench clock drives it; levels change just after a rising edge
`timescale 1ns/1ps

module timer_pins_model (
	input  wire logic clk_i,
	output logic      first_event_pin_o,
	output logic      second_event_pin_o,
	output logic      first_gate_o,
	output logic      second_gate_o
);
	// ------------------------------------------------------------------------
	// idle levels
	// ------------------------------------------------------------------------
	// pins idle high so the first low level is a true falling edge
	initial begin
		first_event_pin_o  = 1'b1;
		second_event_pin_o = 1'b1;
		first_gate_o       = 1'b0;
		second_gate_o      = 1'b0;
	end

	// ------------------------------------------------------------------------
	// stimulus tasks
	// ------------------------------------------------------------------------
	// each level stays three clocks, above the one-clock minimum, so the rate is clk/6
	task automatic pulse(input int which, input int n);
		repeat (n) begin
			@(posedge clk_i);
			if (which == 0) first_event_pin_o <= 1'b0;
			else second_event_pin_o <= 1'b0;
			repeat (3) @(posedge clk_i);
			if (which == 0) first_event_pin_o <= 1'b1;
			else second_event_pin_o <= 1'b1;
			repeat (2) @(posedge clk_i);
		end
		// let the synchroniser and edge compare settle before anyone reads
		repeat (5) @(posedge clk_i);
	endtask : pulse

	// gate level change, then time for the two-flop synchroniser
	task automatic set_gate(input int which, input logic lvl);
		@(posedge clk_i);
		if (which == 0) first_gate_o <= lvl;
		else second_gate_o <= lvl;
		repeat (4) @(posedge clk_i);
	endtask : set_gate
endmodule : timer_pins_model

/* tb/dual_classic_counter_timer_test.sv */
// self-checking bench for the dual counter/timer, register access over classic Wishbone
// assumes: pins come from timer_pins_model; design answers every request with ack_o
`timescale 1ns/1ps
`include "dual_timer_consts.svh"

module dual_classic_counter_timer_test;
	logic        clk;
	logic        rst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [11:0] adr;
	logic [31:0] dat_w;
	logic [31:0] rdat;
	logic        ack;
	logic        ev0, ev1, gt0, gt1;
	logic        xtick;
	logic [1:0]  vec_ack;
	logic        ovf_pulse;
	logic        irq;
	int          err_count;
	int          samples_checked;
	int          ovf_count = 0;
	int          p0;

	dual_classic_counter_timer dut_u (
		.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
		.dat_i(dat_w), .dat_o(rdat), .ack_o(ack), .first_event_pin_i(ev0), .second_event_pin_i(ev1),
		.first_ext_gate_input_i(gt0), .second_ext_gate_input_i(gt1), .ext_scaled_tick_i(xtick),
		.irq_vector_ack_i(vec_ack), .second_overflow_pulse_o(ovf_pulse), .irq_o(irq));

	timer_pins_model pins_u (.clk_i(clk), .first_event_pin_o(ev0), .second_event_pin_o(ev1),
		.first_gate_o(gt0), .second_gate_o(gt1));

	// ------------------------------------------------------------------------
	// clock, watchdog and pulse counter
	// ------------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// the tests need well under a thousand clocks; twenty thousand means a hang
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		results();
	end

	always @(posedge clk) if (ovf_pulse === 1'b1) ovf_count++;

	// ------------------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// ack is read just after the edge, so it is the value that edge sampled
	task automatic wb_cycle(input logic [7:0] idx, input logic wr, input logic [7:0] val, output logic [31:0] rd);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= {2'h0, idx, 2'h0};
		dat_w <= {24'h0, val};
		@(posedge clk);
		// no cycle count is assumed; only the watchdog ends a wait
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
		check("ack drop", 32'h0, {31'h0, ack});
	endtask : wb_cycle

	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		logic [31:0] d;
		wb_cycle(idx, 1'b1, val, d);
	endtask : wr

	// upper bytes must read zero, low byte compared under a mask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] exp, input string what);
		logic [31:0] d;
		wb_cycle(idx, 1'b0, 8'h00, d);
		check(what, {24'h0, exp & m}, d & {24'hFFFFFF, m});
	endtask : rdchk

	task automatic results();
		if (err_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results

	// ------------------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------------------
	initial begin
		rst = 1'b1;
		{cyc, stb, we, adr, dat_w, vec_ack, xtick} = '0;
		err_count = 0;
		samples_checked = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// reset values, unmapped place reads zero and ignores writes
		rdchk(`IDX_TIMER_CONTROL, 8'hFF, 8'h00, "control");
		rdchk(`IDX_TIMER_MODE, 8'hFF, 8'h00, "mode");
		rdchk(`IDX_TIMER_CLOCK_SELECT, 8'hFF, 8'h00, "clock select");
		wr(8'h40, 8'h5A);
		rdchk(8'h40, 8'hFF, 8'h00, "unmapped");
		// 13-bit counter from pin edges, start value kept by run
		wr(`IDX_IRQ_ENABLE, 8'h01);
		wr(`IDX_TIMER_MODE, 8'h04);
		wr(`IDX_FIRST_HIGH, 8'hFF);
		wr(`IDX_FIRST_LOW, 8'h1E);
		wr(`IDX_TIMER_CONTROL, 8'h10);
		rdchk(`IDX_FIRST_LOW, 8'h1F, 8'h1E, "low after run");
		pins_u.pulse(0, 1);
		rdchk(`IDX_FIRST_LOW, 8'h1F, 8'h1F, "low one edge");
		rdchk(`IDX_TIMER_CONTROL, 8'h20, 8'h00, "no early flag");
		pins_u.pulse(0, 1);
		rdchk(`IDX_FIRST_LOW, 8'h1F, 8'h00, "13-bit wrap low");
		rdchk(`IDX_FIRST_HIGH, 8'hFF, 8'h00, "13-bit wrap high");
		rdchk(`IDX_TIMER_CONTROL, 8'h20, 8'h20, "first flag");
		rdchk(`IDX_IRQ_STATUS, 8'h03, 8'h01, "irq status");
		check("irq", 32'h1, {31'h0, irq});
		wr(`IDX_TIMER_CONTROL, 8'h10);
		rdchk(`IDX_TIMER_CONTROL, 8'h20, 8'h00, "flag write zero");
		wr(`IDX_IRQ_STATUS, 8'h01);
		check("irq cleared", 32'h0, {31'h0, irq});
		// second timer auto-reload from its high byte, interrupt masked
		wr(`IDX_TIMER_CONTROL, 8'h00);
		wr(`IDX_TIMER_MODE, 8'h60);
		wr(`IDX_SECOND_HIGH, 8'h80);
		wr(`IDX_SECOND_LOW, 8'hFF);
		wr(`IDX_TIMER_CONTROL, 8'h40);
		p0 = ovf_count;
		pins_u.pulse(1, 1);
		rdchk(`IDX_SECOND_LOW, 8'hFF, 8'h80, "reload low");
		rdchk(`IDX_SECOND_HIGH, 8'hFF, 8'h80, "reload high kept");
		rdchk(`IDX_TIMER_CONTROL, 8'hA0, 8'h80, "second flag");
		rdchk(`IDX_IRQ_STATUS, 8'h03, 8'h02, "second status");
		check("masked irq", 32'h0, {31'h0, irq});
		check("overflow pulses", 32'(p0 + 1), 32'(ovf_count));
		@(posedge clk);
		vec_ack <= 2'b10;
		@(posedge clk);
		vec_ack <= 2'b00;
		@(posedge clk);
		rdchk(`IDX_TIMER_CONTROL, 8'h80, 8'h00, "vector clear");
		wr(`IDX_IRQ_STATUS, 8'hFF);
		// gate holds the count until the gate input is active high
		wr(`IDX_TIMER_CONTROL, 8'h00);
		wr(`IDX_GATE_POLARITY, 8'h01);
		wr(`IDX_TIMER_MODE, 8'h0D);
		wr(`IDX_FIRST_LOW, 8'h00);
		wr(`IDX_FIRST_HIGH, 8'h00);
		wr(`IDX_TIMER_CONTROL, 8'h10);
		pins_u.pulse(0, 2);
		rdchk(`IDX_FIRST_LOW, 8'hFF, 8'h00, "gated off");
		pins_u.set_gate(0, 1'b1);
		pins_u.pulse(0, 2);
		rdchk(`IDX_FIRST_LOW, 8'hFF, 8'h02, "gated on");
		// prescaled clk/4 against system clock, 16-bit wrap from 0xFFF0
		wr(`IDX_TIMER_CONTROL, 8'h00);
		wr(`IDX_TIMER_MODE, 8'h01);
		wr(`IDX_TIMER_CLOCK_SELECT, 8'h01);
		wr(`IDX_FIRST_HIGH, 8'hFF);
		wr(`IDX_FIRST_LOW, 8'hF0);
		wr(`IDX_TIMER_CONTROL, 8'h10);
		// about forty clocks: a system clock count would have wrapped, clk/4 has not
		repeat (40) @(posedge clk);
		rdchk(`IDX_TIMER_CONTROL, 8'h20, 8'h00, "prescaled early");
		repeat (80) @(posedge clk);
		rdchk(`IDX_TIMER_CONTROL, 8'h20, 8'h20, "prescaled wrap");
		wr(`IDX_TIMER_CONTROL, 8'h00);
		wr(`IDX_TIMER_CLOCK_SELECT, 8'h08);
		wr(`IDX_FIRST_LOW, 8'hF0);
		wr(`IDX_FIRST_HIGH, 8'hFF);
		wr(`IDX_TIMER_CONTROL, 8'h10);
		repeat (14) @(posedge clk);
		rdchk(`IDX_TIMER_CONTROL, 8'h20, 8'h20, "sysclk wrap");
		// split: low byte counts pin edges, high byte runs on second run bit
		wr(`IDX_TIMER_CONTROL, 8'h00);
		wr(`IDX_TIMER_MODE, 8'h07);
		wr(`IDX_FIRST_HIGH, 8'hFE);
		wr(`IDX_FIRST_LOW, 8'h10);
		wr(`IDX_TIMER_CONTROL, 8'h50);
		pins_u.pulse(0, 2);
		rdchk(`IDX_FIRST_LOW, 8'hFF, 8'h12, "split low");
		rdchk(`IDX_TIMER_CONTROL, 8'hA0, 8'h80, "split high flag");
		// split: mode three holds the second timer, mode zero lets it run
		wr(`IDX_TIMER_CLOCK_SELECT, 8'h18);
		wr(`IDX_TIMER_MODE, 8'h37);
		wr(`IDX_SECOND_LOW, 8'h55);
		repeat (20) @(posedge clk);
		rdchk(`IDX_SECOND_LOW, 8'hFF, 8'h55, "second stopped");
		wr(`IDX_TIMER_MODE, 8'h07);
		wr(`IDX_SECOND_LOW, 8'h40);
		rdchk(`IDX_SECOND_LOW, 8'h1F, 8'h02, "second runs");
		// prescale select 3 counts only the external scaled tick
		wr(`IDX_TIMER_CONTROL, 8'h00);
		wr(`IDX_TIMER_MODE, 8'h01);
		wr(`IDX_TIMER_CLOCK_SELECT, 8'h03);
		wr(`IDX_FIRST_LOW, 8'h20);
		wr(`IDX_TIMER_CONTROL, 8'h10);
		repeat (20) @(posedge clk);
		xtick <= 1'b1;
		repeat (3) @(posedge clk);
		xtick <= 1'b0;
		rdchk(`IDX_FIRST_LOW, 8'hFF, 8'h23, "external tick");
		results();
	end
endmodule : dual_classic_counter_timer_test
